/* hw/bpr_route.v */
// Routing of three regulator power-good change events onto seven multipurpose pins
//
// Contract
// - Regulator 1 bits 2..0 steer its event to pins 2..0 when set.
// - Regulator 2 bit 7 is read-only flag of a power-good change.
// - Regulator 2 bits 6..0 steer its event to matching pins when set.
// - Regulator 3 bit 7 is read-only flag of a power-good change.
// - Regulator 3 bits 6 and 5 steer its event to pins 6, 5.
// - A pin carries a routed interrupt only when configured as output.
`timescale 1ns/1ps
`include "bpr_map.vh"
module bpr_route (
  // Clock and reset
  input  wire                   clk,
  input  wire                   rst,
  // Register port
  input  wire [`BPR_ADDR_W-1:0] reg_addr,
  input  wire                   reg_wr,
  input  wire                   reg_rd,
  input  wire [`BPR_DATA_W-1:0] reg_wdata,
  output reg  [`BPR_DATA_W-1:0] reg_rdata,
  output reg                    reg_ack,
  // Regulator power-good levels
  input  wire [2:0]             power_good,
  // Pin direction, one bit per pin, 1 = output
  input  wire [`BPR_NUM_PINS-1:0] pin_direction_out,
  // Multipurpose pin drive
  output reg  [`BPR_NUM_PINS-1:0] multipurpose_pin_irq_q,
  output reg  [`BPR_NUM_PINS-1:0] multipurpose_pin_oe_n_q
);

  // ==========================================================
  // Storage and internal nets
  // Only bits 6..0 are stored; bit 7 reads back the event flag
  reg  [`BPR_NUM_PINS-1:0] route_q [0:`BPR_NUM_REGS-1];
  integer                  i;
  // Decoded access
  wire [1:0]               acc_idx;
  wire [2:0]               wr_sel;
  wire [2:0]               rd_sel;
  wire                     ack_d;
  // Event flags, one per regulator
  wire [2:0]               flag;
  wire                     reg1_pg_event_flag;
  wire                     reg2_pg_event_flag;
  wire                     reg3_pg_event_flag;
  // Select fields of the partly implemented registers
  wire                     reg1_route_pin2;
  wire                     reg1_route_pin1;
  wire                     reg1_route_pin0;
  wire                     reg3_route_pin6;
  wire                     reg3_route_pin5;
  // Read path
  wire [`BPR_DATA_W-1:0]   reg1_byte;
  wire [`BPR_DATA_W-1:0]   reg2_byte;
  wire [`BPR_DATA_W-1:0]   reg3_byte;
  reg  [`BPR_DATA_W-1:0]   rdata_d;
  // Pin path
  wire [`BPR_NUM_PINS-1:0] reg1_pins;
  wire [`BPR_NUM_PINS-1:0] reg2_pins;
  wire [`BPR_NUM_PINS-1:0] reg3_pins;
  reg  [`BPR_NUM_PINS-1:0] pin_irq_d;
  wire [`BPR_NUM_PINS-1:0] pin_drive_d;
  wire [`BPR_NUM_PINS-1:0] pin_oe_n_d;

  // ==========================================================
  // Helpers
  // Writable select bits of each routing register
  function [`BPR_NUM_PINS-1:0] route_mask;
    input [1:0] idx;
    begin
      case (idx)
        2'h0:    route_mask = `BPR_REG1_ROUTE_M;
        2'h1:    route_mask = `BPR_FULL_ROUTE_M;
        2'h2:    route_mask = `BPR_REG3_ROUTE_M;
        default: route_mask = `BPR_ROUTE_RST;
      endcase
    end
  endfunction

  // Register number of an address; 3 means unmapped
  function [1:0] reg_index;
    input [`BPR_ADDR_W-1:0] a;
    begin
      case (a)
        `BPR_OFF_REG1: reg_index = 2'h0;
        `BPR_OFF_REG2: reg_index = 2'h1;
        `BPR_OFF_REG3: reg_index = 2'h2;
        default:       reg_index = 2'h3;
      endcase
    end
  endfunction

  // One-hot select of a register number, empty when unmapped
  function [2:0] reg_onehot;
    input [1:0] idx;
    begin
      case (idx)
        2'h0:    reg_onehot = 3'h1;
        2'h1:    reg_onehot = 3'h2;
        2'h2:    reg_onehot = 3'h4;
        default: reg_onehot = 3'h0;
      endcase
    end
  endfunction

  // Copy of one event on the pins its select bits name
  function [`BPR_NUM_PINS-1:0] gate_route;
    input [`BPR_NUM_PINS-1:0] sel;
    input                     evt;
    begin
      gate_route = sel & {`BPR_NUM_PINS{evt}};
    end
  endfunction

  // ==========================================================
  // Address decode
  // Unmapped addresses select nothing: writes vanish, reads give zero
  assign acc_idx = reg_index(reg_addr);
  assign wr_sel  = reg_wr ? reg_onehot(acc_idx) : 3'h0;
  assign rd_sel  = reg_rd ? reg_onehot(acc_idx) : 3'h0;
  assign ack_d   = reg_wr | reg_rd;

  // ==========================================================
  // Event flags
  // Reading a flag clears it; a change in the same cycle still sets it
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : gen_flag
      bpr_flag u_flag (
        .clk        (clk),
        .rst        (rst),
        .power_good (power_good[g]),
        .clear      (rd_sel[g]),
        .flag_q     (flag[g])
      );
    end
  endgenerate

  assign reg1_pg_event_flag = flag[0];
  assign reg2_pg_event_flag = flag[1];
  assign reg3_pg_event_flag = flag[2];

  // ==========================================================
  // Routing registers
  always @(posedge clk) begin
    if (rst) begin
      for (i = 0; i < `BPR_NUM_REGS; i = i + 1) begin
        route_q[i] <= `BPR_ROUTE_RST;
      end
    end else begin
      for (i = 0; i < `BPR_NUM_REGS; i = i + 1) begin
        if (wr_sel[i]) begin
          // Unimplemented select bits stay zero so they cannot route
          route_q[i] <= reg_wdata[`BPR_ROUTE_MSB:0] & route_mask(i[1:0]);
        end
      end
    end
  end

  // ==========================================================
  // Read path
  assign reg1_route_pin2 = route_q[0][2];
  assign reg1_route_pin1 = route_q[0][1];
  assign reg1_route_pin0 = route_q[0][0];
  assign reg3_route_pin6 = route_q[2][6];
  assign reg3_route_pin5 = route_q[2][5];

  // Bit 7 is never written; it reads as the live flag state
  assign reg1_byte = {reg1_pg_event_flag, 4'h0,
                      reg1_route_pin2, reg1_route_pin1, reg1_route_pin0};
  assign reg2_byte = {reg2_pg_event_flag, route_q[1]};
  assign reg3_byte = {reg3_pg_event_flag, reg3_route_pin6, reg3_route_pin5, 5'h00};

  always @* begin
    case (acc_idx)
      2'h0:    rdata_d = reg1_byte;
      2'h1:    rdata_d = reg2_byte;
      2'h2:    rdata_d = reg3_byte;
      default: rdata_d = 8'h00;
    endcase
  end

  // Data holds between reads, so a late look still sees the last byte
  always @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
      reg_ack   <= 1'h0;
    end else begin
      reg_ack <= ack_d;
      if (reg_rd) begin
        reg_rdata <= rdata_d;
      end
    end
  end

  // ==========================================================
  // Pin combining
  assign reg1_pins = gate_route(route_q[0], reg1_pg_event_flag);
  assign reg2_pins = gate_route(route_q[1], reg2_pg_event_flag);
  assign reg3_pins = gate_route(route_q[2], reg3_pg_event_flag);

  // A pin shared by several regulators shows any of their events
  always @* begin
    pin_irq_d = reg1_pins | reg2_pins | reg3_pins;
  end

  // Input pins are never driven, so a routed event cannot reach them
  assign pin_drive_d = pin_irq_d & pin_direction_out;
  assign pin_oe_n_d  = ~pin_direction_out;

  always @(posedge clk) begin
    if (rst) begin
      multipurpose_pin_irq_q  <= `BPR_DIR_RST;
      multipurpose_pin_oe_n_q <= ~`BPR_DIR_RST;
    end else begin
      multipurpose_pin_irq_q  <= pin_drive_d;
      multipurpose_pin_oe_n_q <= pin_oe_n_d;
    end
  end

endmodule

/* common/bpr_map.vh */
// Register offsets, field positions and reset values for the power-good routing block
`ifndef BPR_MAP_VH
`define BPR_MAP_VH

`define BPR_ADDR_W        8
`define BPR_DATA_W        8
`define BPR_NUM_PINS      7
`define BPR_NUM_REGS      3

`define BPR_OFF_REG1      8'h70
`define BPR_OFF_REG2      8'h71
`define BPR_OFF_REG3      8'h72

`define BPR_FLAG_BIT      7
`define BPR_ROUTE_MSB     6
`define BPR_REG1_ROUTE_M  7'h07
`define BPR_REG3_ROUTE_M  7'h60
`define BPR_FULL_ROUTE_M  7'h7F

`define BPR_ROUTE_RST     7'h00
`define BPR_DIR_RST       7'h00

`endif

/* hw/bpr_flag.v */
// Sticky power-good change flag for one regulator
`timescale 1ns/1ps
module bpr_flag (
  // Clock and reset
  input  wire clk,
  input  wire rst,
  // Power-good level and clear strobe
  input  wire power_good,
  input  wire clear,
  // Flag
  output reg  flag_q
);

  reg pg_prev_q;
  reg primed_q;

  // ==========================================================
  // Change detect, set wins over clear
  // Primed avoids a false event from the unknown level at reset
  always @(posedge clk) begin
    if (rst) begin
      pg_prev_q <= 1'b0;
      primed_q  <= 1'b0;
      flag_q    <= 1'b0;
    end else begin
      pg_prev_q <= power_good;
      primed_q  <= 1'b1;
      if (primed_q && (power_good != pg_prev_q)) begin
        flag_q <= 1'b1;
      end else if (clear) begin
        flag_q <= 1'b0;
      end
    end
  end

endmodule

/* verification/bpr_host.sv */
// Host side model of the interrupt pins
`timescale 1ns/1ps
module bpr_host (
  // Pin drive from the device, level seen by the host
  input  wire [6:0] irq,
  input  wire [6:0] oe_n,
  output wire [6:0] seen
);
  // Undriven pin reads the pull-down level
  assign seen = irq & ~oe_n;
endmodule

/* verification/bpr_route_sva.sv */
// Port checker for the power-good routing block
`timescale 1ns/1ps
module bpr_route_sva (
  // Clock, reset, register port
  input wire       clk,
  input wire       rst,
  input wire [7:0] reg_addr,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  input wire       reg_ack,
  // Regulators and pins
  input wire [2:0] power_good,
  input wire [6:0] pin_direction_out,
  input wire [6:0] multipurpose_pin_irq_q,
  input wire [6:0] multipurpose_pin_oe_n_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_wr_rd(a); reg_wr && reg_addr == a ##2 reg_rd && reg_addr == a; endsequence
  sequence s_chg(k); $changed(power_good[k]) && !$past(rst) ##1 !reg_rd [*4]; endsequence
  property p_rt(a, m); s_wr_rd(a) |=> reg_rdata[6:0] == ($past(reg_wdata, 3) & m); endproperty
  property p_fl(k, a); s_chg(k) ##1 reg_rd && reg_addr == a |=> reg_rdata[7]; endproperty
  route_one_a: assert property (p_rt(8'h70, 7'h07)) else $error("route1 bad");
  route_two_a: assert property (p_rt(8'h71, 7'h7F)) else $error("route2 bad");
  route_three_a: assert property (p_rt(8'h72, 7'h60)) else $error("route3 bad");
  flag_two_a: assert property (p_fl(1, 8'h71)) else $error("flag2 bad");
  flag_three_a: assert property (p_fl(2, 8'h72)) else $error("flag3 bad");
  pin_gate_a: assert property (!$past(rst) |->
    (multipurpose_pin_irq_q & ~$past(pin_direction_out)) == 7'h00) else $error("gate bad");
  reg_ack_a: assert property (!$past(rst) |-> reg_ack == $past(reg_wr || reg_rd))
    else $error("ack bad");
endmodule
bind bpr_route bpr_route_sva u_sva (.clk, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
  .reg_rdata, .reg_ack, .power_good, .pin_direction_out, .multipurpose_pin_irq_q,
  .multipurpose_pin_oe_n_q);

/* verification/tb_buck_power_good_irq_pin_routing.sv */
// Bench for the power-good routing block
`timescale 1ns/1ps
module tb_buck_power_good_irq_pin_routing;
  logic        clk = 0, rst = 1, wr = 0, rd = 0, rd_q = 0, ack;
  logic [7:0]  addr = 8'h00, wd = 8'h00, rdata, q[$];
  logic [2:0]  pg = 3'h0;
  logic [6:0]  dir = 7'h00, irq, oe_n, seen, m[3] = '{7'h07, 7'h7F, 7'h60};
  int          err_total = 0, cmp_count = 0;
  logic [31:0] s = 83;
  always #2 clk = ~clk;
  bpr_route DUT (.clk, .rst, .reg_addr(addr), .reg_wr(wr), .reg_rd(rd), .reg_wdata(wd),
    .reg_rdata(rdata), .reg_ack(ack), .power_good(pg), .pin_direction_out(dir),
    .multipurpose_pin_irq_q(irq), .multipurpose_pin_oe_n_q(oe_n));
  bpr_host host (.irq, .oe_n, .seen);
  // Only read acknowledges carry a noted byte; write ones are skipped
  always @(posedge clk) rd_q <= rd;
  always @(posedge clk) if (ack && rd_q) chk(rdata, q.pop_front());
  task automatic chk(input logic [7:0] a, b);
    cmp_count++;
    if (a !== b) begin
      err_total++;
      $display("unexpected t=%0t seen=%h exp=%h", $time, a, b);
    end
  endtask
  // Reads note their expected byte for the monitor
  task automatic acc(input logic w, input logic [7:0] a, d);
    @(posedge clk);
    {addr, wd, wr, rd} <= {a, d, w, !w};
    if (!w) q.push_back(d);
    @(posedge clk);
    {wr, rd} <= 2'b00;
  endtask
  task automatic ev(input int k, input logic [6:0] p, input logic [7:0] a, e);
    @(posedge clk);
    pg[k] <= !pg[k];
    repeat (4) @(posedge clk);
    #1;
    chk({1'b0, seen}, {1'b0, p});
    chk({1'b0, oe_n}, {1'b0, ~dir});
    acc(1'b0, a, e);
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    acc(1'b1, 8'h75, 8'hFF);
    acc(1'b0, 8'h75, 8'h00);
    for (int i = 0; i < 3; i++) begin
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      acc(1'b1, 8'h70 + i[7:0], s[7:0]);
      acc(1'b0, 8'h70 + i[7:0], {1'b0, s[6:0] & m[i]});
    end
    dir <= 7'h3F;
    acc(1'b1, 8'h70, 8'h01);
    acc(1'b1, 8'h71, 8'h41);
    acc(1'b1, 8'h72, 8'h60);
    ev(0, 7'h01, 8'h70, 8'h81);
    ev(2, 7'h20, 8'h72, 8'hE0);
    ev(1, 7'h01, 8'h71, 8'hC1);
    // Two regulators share pin 5; clearing one must leave the other showing
    acc(1'b1, 8'h71, 8'h20);
    ev(2, 7'h20, 8'h71, 8'h20);
    ev(1, 7'h20, 8'h72, 8'hE0);
    ev(0, 7'h21, 8'h71, 8'hA0);
    repeat (4) @(posedge clk);
    summarize();
  end
  initial begin
    #2000;
    err_total++;
    summarize();
  end
endmodule
